//--- rtl/dims_host.sv
// Host end: edge-driven interrupt service engine with an APB slave
//
// Implementation choices: the APB slave port and the placing of the registers.
`default_nettype none
module dims_host (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irqOut,
  dims_if.host link
);
  dims_pkg::dims_state_e state_q;
  logic req_q;
  logic wr_q;
  logic [15:0] addr_q;
  logic [31:0] wdata_q;
  logic line1Sel_q;
  logic [4:0] need_q;
  logic prev0_q;
  logic prev1_q;
  logic pend0_q;
  logic pend1_q;
  logic enable_q;
  logic [2:0] hirq_q;
  logic [2:0] hmask_q;
  logic [31:0] lastSt0_q;
  logic [31:0] lastSt1_q;
  logic [31:0] lastDet_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;

  // Detail registers to read: noload, event, current_peak_detail, voltage_peak_detail, sign
  function automatic logic [4:0] detailNeed(input logic l1,
                                            input logic [31:0] st);
    detailNeed = l1 ? {1'b0, |(st & dims_pkg::GRP_V_PEAK),
      |(st & dims_pkg::GRP_I_PEAK), |(st & dims_pkg::GRP_PH_EVENT),
      |(st & dims_pkg::GRP_PH_NOLOAD)}
      : {|(st & dims_pkg::GRP_PH_SIGN), 4'h0};
  endfunction

  function automatic logic [15:0] detailAddr(input logic [4:0] n);
    detailAddr = n[0] ? dims_pkg::DEV_PH_NOLOAD :
      n[1] ? dims_pkg::DEV_PH_EVENT :
      n[2] ? dims_pkg::DEV_I_PEAK :
      n[3] ? dims_pkg::DEV_V_PEAK : dims_pkg::DEV_PH_SIGN;
  endfunction

  wire line0 = link.firstIntOutN;
  wire line1 = link.secondIntOutN;
  wire fall0 = prev0_q & ~line0;
  wire fall1 = prev1_q & ~line1;
  // A still-low line is also served, covering an event that raced the clear
  wire want0 = pend0_q | ~line0;
  wire want1 = pend1_q | ~line1;
  wire start = enable_q & (state_q == dims_pkg::ST_IDLE) & (want0 | want1);
  wire pick1 = ~want0;
  wire ack = link.regAck & req_q;
  wire [4:0] needNow = detailNeed(line1Sel_q, link.regRdata);
  wire [4:0] needNext = need_q & (need_q - 5'h01);
  wire [15:0] statAddr =
    line1Sel_q ? dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS : dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS;
  wire [31:0] statVal = line1Sel_q ? lastSt1_q : lastSt0_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= dims_pkg::ST_IDLE;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
      line1Sel_q <= 1'b0;
      need_q <= 5'h00;
      lastSt0_q <= 32'h0000_0000;
      lastSt1_q <= 32'h0000_0000;
      lastDet_q <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        dims_pkg::ST_IDLE:
        begin
          if (start)
          begin
            line1Sel_q <= pick1;
            req_q <= 1'b1;
            wr_q <= 1'b0;
            addr_q <= pick1 ? dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS
                            : dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS;
            state_q <= dims_pkg::ST_RD_STAT;
          end
        end
        dims_pkg::ST_RD_STAT:
        begin
          if (ack)
          begin
            if (line1Sel_q)
            begin
              lastSt1_q <= link.regRdata;
            end
            else
            begin
              lastSt0_q <= link.regRdata;
            end
            need_q <= needNow;
            wr_q <= needNow == 5'h00;
            addr_q <= needNow == 5'h00 ? statAddr
                                       : detailAddr(needNow);
            wdata_q <= link.regRdata;
            state_q <= needNow == 5'h00 ? dims_pkg::ST_WR_BACK
                                        : dims_pkg::ST_RD_DET;
          end
        end
        dims_pkg::ST_RD_DET:
        begin
          if (ack)
          begin
            lastDet_q <= link.regRdata;
            need_q <= needNext;
            wr_q <= needNext == 5'h00;
            addr_q <= needNext == 5'h00 ? statAddr
                                        : detailAddr(needNext);
            wdata_q <= statVal;
            state_q <= needNext == 5'h00 ? dims_pkg::ST_WR_BACK
                                         : dims_pkg::ST_RD_DET;
          end
        end
        dims_pkg::ST_WR_BACK:
        begin
          if (ack)
          begin
            req_q <= 1'b0;
            wr_q <= 1'b0;
            state_q <= dims_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_q <= dims_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Edge flag cleared as service starts; a new edge still wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prev0_q <= 1'b1;
      prev1_q <= 1'b1;
      pend0_q <= 1'b0;
      pend1_q <= 1'b0;
    end
    else
    begin
      prev0_q <= line0;
      prev1_q <= line1;
      pend0_q <= fall0 | (pend0_q & ~(start & ~pick1));
      pend1_q <= fall1 | (pend1_q & ~(start & pick1));
    end
  end

  wire apbAcc = psel & penable & pready_q;
  wire apbWr = apbAcc & pwrite;
  wire hitCtrl = paddr == dims_pkg::HOST_CTRL;
  wire hitStat = paddr == dims_pkg::HOST_IRQ_STAT;
  wire hitMask = paddr == dims_pkg::HOST_IRQ_MASK;
  wire hitSt0 = paddr == dims_pkg::HOST_LAST_ST0;
  wire hitSt1 = paddr == dims_pkg::HOST_LAST_ST1;
  wire hitDet = paddr == dims_pkg::HOST_LAST_DET;
  wire mapped = hitCtrl | hitStat | hitMask | hitSt0 | hitSt1 | hitDet;
  wire doneAck = ack & (state_q == dims_pkg::ST_WR_BACK);
  wire detAck = ack & (state_q == dims_pkg::ST_RD_DET);
  wire [2:0] hirqSet = {detAck, doneAck & line1Sel_q, doneAck & ~line1Sel_q};
  wire [2:0] hirqClr = (apbWr & hitStat) ? pwdata[2:0] : 3'h0;
  wire [2:0] hirq_d = (hirq_q & ~hirqClr) | hirqSet;
  wire [2:0] hmask_d = (apbWr & hitMask) ? pwdata[2:0] : hmask_q;
  wire [31:0] apbMux =
    hitCtrl ? {31'h0000_0000, enable_q} :
    hitStat ? {29'h0000_0000, hirq_q} :
    hitMask ? {29'h0000_0000, hmask_q} :
    hitSt0 ? lastSt0_q :
    hitSt1 ? lastSt1_q :
    hitDet ? lastDet_q : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      enable_q <= dims_pkg::CTRL_RST;
      hirq_q <= dims_pkg::HIRQ_RST;
      hmask_q <= dims_pkg::HIRQ_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end
    else
    begin
      enable_q <= (apbWr & hitCtrl) ? pwdata[0] : enable_q;
      hirq_q <= hirq_d;
      hmask_q <= hmask_d;
      // One wait state: pready rises in the second access cycle
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? apbMux : prdata_q;
      irq_q <= |(hirq_d & hmask_d);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irqOut = irq_q;
  assign link.regReq = req_q;
  assign link.regWr = wr_q;
  assign link.regAddr = addr_q;
  assign link.regWdata = wdata_q;
endmodule
`default_nettype wire

//--- shared/dims_pkg.sv
// Constants shared by both ends of the dual interrupt mask/status unit
// Function
// - Each output has a 32-bit enable mask
// - Internal event sets its status flag to one
// - Output low while any enabled flag set
// - Flags set regardless of mask state
// - Writing one clears flag; zero leaves it
// - Output stays low until enabled flags cleared
// - After reset every mask bit is cleared
// - Reset-done is unmaskable; mask bit 15 ignored
// - Reset end sets second status bit 15
// - Second bits 0,2 use phase no-load detail
// - Second bits 16,17,18 use phase event detail
// - Second bits 23,24 use peak detail registers
// - First reversal and sign bits use sign detail
// - Host reads detail before writing status back
// - Host reads status to find the source
// - Host services on falling output edge
// - Host clears edge flag, writes status back
`default_nettype none
package dims_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int DETAIL_W = 16;
  // Device register addresses on the link
  localparam logic [15:0] DEV_FIRST_INT_OUT_N_ENABLE_MASK = 16'h0010;
  localparam logic [15:0] DEV_SECOND_INT_OUT_N_ENABLE_MASK = 16'h0014;
  localparam logic [15:0] DEV_FIRST_INT_OUT_N_EVENT_FLAGS = 16'h0018;
  localparam logic [15:0] DEV_SECOND_INT_OUT_N_EVENT_FLAGS = 16'h001C;
  localparam logic [15:0] DEV_PH_NOLOAD = 16'h0020;
  localparam logic [15:0] DEV_PH_EVENT = 16'h0024;
  localparam logic [15:0] DEV_PH_SIGN = 16'h0028;
  localparam logic [15:0] DEV_I_PEAK = 16'h002C;
  localparam logic [15:0] DEV_V_PEAK = 16'h0030;
  localparam logic [15:0] DEV_SW_RESET = 16'h0034;
  // Field positions and groups
  localparam int RESET_DONE_BIT = 15;
  localparam logic [31:0] RESET_DONE_MASK = 32'h0000_8000;
  localparam logic [31:0] GRP_PH_NOLOAD = 32'h0000_0005;
  localparam logic [31:0] GRP_PH_EVENT = 32'h0007_0000;
  localparam logic [31:0] GRP_I_PEAK = 32'h0080_0000;
  localparam logic [31:0] GRP_V_PEAK = 32'h0100_0000;
  // Bits 6..13 and 18 of the first bank
  localparam logic [31:0] GRP_PH_SIGN = 32'h0004_3FC0;
  // Reset values
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  // Host APB register offsets
  localparam logic [7:0] HOST_CTRL = 8'h00;
  localparam logic [7:0] HOST_IRQ_STAT = 8'h04;
  localparam logic [7:0] HOST_IRQ_MASK = 8'h08;
  localparam logic [7:0] HOST_LAST_ST0 = 8'h0C;
  localparam logic [7:0] HOST_LAST_ST1 = 8'h10;
  localparam logic [7:0] HOST_LAST_DET = 8'h14;
  localparam int HIRQ_DONE0 = 0;
  localparam int HIRQ_DONE1 = 1;
  localparam int HIRQ_DETAIL = 2;
  localparam logic [2:0] HIRQ_RST = 3'h0;
  localparam logic CTRL_RST = 1'b0;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RD_STAT = 4'b0010,
    ST_RD_DET = 4'b0100,
    ST_WR_BACK = 4'b1000
  } dims_state_e;
endpackage
`default_nettype wire

//--- shared/dims_if.sv
// Link between the metering device and its host controller
`default_nettype none
interface dims_if;
  logic regReq;
  logic regWr;
  logic [15:0] regAddr;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic regAck;
  logic firstIntOutN;
  logic secondIntOutN;
  modport device (
    input regReq, regWr, regAddr, regWdata,
    output regRdata, regAck, firstIntOutN, secondIntOutN
  );
  modport host (
    output regReq, regWr, regAddr, regWdata,
    input regRdata, regAck, firstIntOutN, secondIntOutN
  );
endinterface
`default_nettype wire

//--- rtl/dims_flag_bank.sv
// One mask/status pair driving one active-low interrupt output
`default_nettype none
module dims_flag_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] setEvent,
  input wire logic [31:0] forceEnable,
  input wire logic wrMask,
  input wire logic wrStatus,
  input wire logic [31:0] wdata,
  output logic [31:0] mask_q,
  output logic [31:0] status_q,
  output logic intOutN_q
);
  wire [31:0] clearBits = wrStatus ? wdata : 32'h0000_0000;
  // Set term applied after the clear so a racing event survives
  wire [31:0] status_d =
    (status_q & ~clearBits) | setEvent;
  wire [31:0] mask_d = wrMask ? wdata : mask_q;
  wire [31:0] effMask = mask_d | forceEnable;
  wire anyLive = |(status_d & effMask);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask_q <= dims_pkg::MASK_RST;
      status_q <= dims_pkg::STATUS_RST;
      intOutN_q <= 1'b1;
    end
    else
    begin
      mask_q <= mask_d;
      status_q <= status_d;
      // Low until every enabled flag is gone
      intOutN_q <= ~anyLive;
    end
  end
endmodule
`default_nettype wire

//--- rtl/dims_device.sv
// Device end: two interrupt banks, phase detail registers, link slave
`default_nettype none
module dims_device (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] irq0Event,
  input wire logic [31:0] irq1Event,
  input wire logic [15:0] phaseNoloadIn,
  input wire logic [15:0] phaseEventIn,
  input wire logic [15:0] phaseSignIn,
  input wire logic [31:0] currentPeakIn,
  input wire logic [31:0] voltagePeakIn,
  output logic swResetBusy_q,
  dims_if.device link
);
  logic swRst_q;
  logic rstDonePend_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic firstN_q;
  logic secondN_q;
  logic [15:0] phaseNoload_q;
  logic [15:0] phaseEvent_q;
  logic [15:0] phaseSign_q;
  logic [31:0] currentPeak_q;
  logic [31:0] voltagePeak_q;
  logic [31:0] first_int_out_n_enable_mask;
  logic [31:0] second_int_out_n_enable_mask;
  logic [31:0] first_int_out_n_event_flags;
  logic [31:0] second_int_out_n_event_flags;
  logic bank0N;
  logic bank1N;

  // Software reset acts like the pin reset on everything but the link
  wire localRst = sys_rst | swRst_q;

  // A request is taken once; the host holds it until it sees the ack
  wire take = link.regReq & ~ack_q;
  wire takeWr = take & link.regWr;
  wire takeRd = take & ~link.regWr;

  wire hitMask0 = link.regAddr == dims_pkg::DEV_FIRST_INT_OUT_N_ENABLE_MASK;
  wire hitMask1 = link.regAddr == dims_pkg::DEV_SECOND_INT_OUT_N_ENABLE_MASK;
  wire hitStat0 = link.regAddr == dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS;
  wire hitStat1 = link.regAddr == dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS;
  wire hitPhNl = link.regAddr == dims_pkg::DEV_PH_NOLOAD;
  wire hitPhEv = link.regAddr == dims_pkg::DEV_PH_EVENT;
  wire hitPhSg = link.regAddr == dims_pkg::DEV_PH_SIGN;
  wire hitIPk = link.regAddr == dims_pkg::DEV_I_PEAK;
  wire hitVPk = link.regAddr == dims_pkg::DEV_V_PEAK;
  wire hitSwRst = link.regAddr == dims_pkg::DEV_SW_RESET;

  // Reset-done fires on the first cycle after any reset ends
  wire rstDoneEvt = rstDonePend_q & ~localRst;
  wire [31:0] rstDoneVec =
    rstDoneEvt ? dims_pkg::RESET_DONE_MASK : 32'h0000_0000;
  wire [31:0] bank1Set = irq1Event | rstDoneVec;

  // Detail registers follow the event that raises their flag
  wire capPhNl = |(irq1Event & dims_pkg::GRP_PH_NOLOAD);
  wire capPhEv = |(irq1Event & dims_pkg::GRP_PH_EVENT);
  wire capIPk = |(irq1Event & dims_pkg::GRP_I_PEAK);
  wire capVPk = |(irq1Event & dims_pkg::GRP_V_PEAK);
  wire capPhSg = |(irq0Event & dims_pkg::GRP_PH_SIGN);

  wire [31:0] phNlWord = {16'h0000, phaseNoload_q};
  wire [31:0] phEvWord = {16'h0000, phaseEvent_q};
  wire [31:0] phSgWord = {16'h0000, phaseSign_q};

  // Unmapped addresses read as zero and ignore writes
  wire [31:0] readMux =
    hitMask0 ? first_int_out_n_enable_mask :
    hitMask1 ? second_int_out_n_enable_mask :
    hitStat0 ? first_int_out_n_event_flags :
    hitStat1 ? second_int_out_n_event_flags :
    hitPhNl ? phNlWord :
    hitPhEv ? phEvWord :
    hitPhSg ? phSgWord :
    hitIPk ? currentPeak_q :
    hitVPk ? voltagePeak_q :
    32'h0000_0000;

  dims_flag_bank firstBank (
    .clk(clk),
    .rst(localRst),
    .setEvent(irq0Event),
    .forceEnable(32'h0000_0000),
    .wrMask(takeWr & hitMask0),
    .wrStatus(takeWr & hitStat0),
    .wdata(link.regWdata),
    .mask_q(first_int_out_n_enable_mask),
    .status_q(first_int_out_n_event_flags),
    .intOutN_q(bank0N)
  );

  // Bank 1 forces bit 15 on, so its stored mask bit has no effect
  dims_flag_bank secondBank (
    .clk(clk),
    .rst(localRst),
    .setEvent(bank1Set),
    .forceEnable(dims_pkg::RESET_DONE_MASK),
    .wrMask(takeWr & hitMask1),
    .wrStatus(takeWr & hitStat1),
    .wdata(link.regWdata),
    .mask_q(second_int_out_n_enable_mask),
    .status_q(second_int_out_n_event_flags),
    .intOutN_q(bank1N)
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      swRst_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      swRst_q <= takeWr & hitSwRst;
      ack_q <= take;
      rdata_q <= takeRd ? readMux : rdata_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (localRst)
    begin
      rstDonePend_q <= 1'b1;
      swResetBusy_q <= 1'b1;
    end
    else
    begin
      rstDonePend_q <= 1'b0;
      swResetBusy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (localRst)
    begin
      phaseNoload_q <= 16'h0000;
      phaseEvent_q <= 16'h0000;
      phaseSign_q <= 16'h0000;
      currentPeak_q <= 32'h0000_0000;
      voltagePeak_q <= 32'h0000_0000;
    end
    else
    begin
      if (capPhNl)
      begin
        phaseNoload_q <= phaseNoloadIn;
      end
      if (capPhEv)
      begin
        phaseEvent_q <= phaseEventIn;
      end
      if (capPhSg)
      begin
        phaseSign_q <= phaseSignIn;
      end
      if (capIPk)
      begin
        currentPeak_q <= currentPeakIn;
      end
      if (capVPk)
      begin
        voltagePeak_q <= voltagePeakIn;
      end
    end
  end

  // Pins follow the banks; one extra stage keeps the port off logic
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      firstN_q <= 1'b1;
      secondN_q <= 1'b1;
    end
    else
    begin
      firstN_q <= bank0N;
      secondN_q <= bank1N;
    end
  end

  assign link.regAck = ack_q;
  assign link.regRdata = rdata_q;
  assign link.firstIntOutN = firstN_q;
  assign link.secondIntOutN = secondN_q;
endmodule
`default_nettype wire

//--- sim/dims_sva.sv
// Concurrent checks on the link joining the device and host ends
`default_nettype none
module dims_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic regReq,
  input wire logic regWr,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic regAck,
  input wire logic firstIntOutN,
  input wire logic secondIntOutN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic isStat1;
  logic seenRd_q;
  logic [31:0] lastStat_q;
  logic wbTake;
  assign isStat1 = (regAddr == dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS);
  assign wbTake = regReq && !regAck && regWr && isStat1;
  // Address is still held at the ack edge, so the ack edge names the access
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      seenRd_q <= 1'b0;
    else if (regAck && isStat1)
      seenRd_q <= !regWr;
  end
  always_ff @(posedge clk)
  begin
    if (regAck && isStat1 && !regWr)
      lastStat_q <= regRdata;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_take_ack: assert property (regReq && !regAck |=>
    regAck ##1 !regAck)
    else $error("link request not answered by one ack pulse");
  a_req_held: assert property (regReq && !regAck |=> regReq &&
    $stable(regAddr) && $stable(regWr) && $stable(regWdata))
    else $error("link request changed before its ack");
  a_rdata_hold: assert property (regAck |=> $stable(regRdata))
    else $error("read data moved right after its ack");
  a_reset_complete_flag_pin: assert property ($fell(sys_rst) |->
    secondIntOutN ##[1:3] !secondIntOutN)
    else $error("second line not pulled low after reset");
  a_first_quiet: assert property ($fell(sys_rst) |->
    firstIntOutN [*3])
    else $error("first line active straight after reset");
  a_second_hold: assert property (!secondIntOutN && !regAck |=>
    !secondIntOutN)
    else $error("second line released without a write");
  a_second_rise: assert property ($rose(secondIntOutN) |->
    $past(regAck && regWr && isStat1))
    else $error("second line rose without a status write");
  a_read_first: assert property (wbTake |-> seenRd_q)
    else $error("status written back before it was read");
  a_wb_same: assert property (wbTake |-> regWdata == lastStat_q)
    else $error("write-back differs from the status read");
  c_reset_complete_flag: cover property ($fell(sys_rst) ##[1:3] !secondIntOutN);
  c_wb: cover property (regAck && regWr && isStat1);
  c_rise: cover property ($rose(secondIntOutN));
  c_detail: cover property (regAck && !regWr &&
    regAddr == dims_pkg::DEV_PH_NOLOAD);
endmodule
`default_nettype wire

//--- sim/dual_irq_mask_status_unit_bench.sv
// Bench: serviced host/device pair plus a device driven from the bench
`default_nettype none
module dual_irq_mask_status_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irqOut;
  logic [31:0] ev0B;
  logic [31:0] ev1B;
  logic [15:0] nl;
  logic [15:0] pe;
  logic [15:0] sg;
  logic [31:0] ip;
  logic [31:0] vp;
  logic [31:0] tmp;
  logic [31:0] ev1A;
  logic swBusyB;
  int bad_count;
  int tests_run;
  dims_if ifA ();
  dims_if ifB ();
  // The serviced pair sees reset-done plus one no-load event from the bench
  dims_device u_dims_device (.clk(clk), .sys_rst(sys_rst), .irq0Event(32'h0),
    .irq1Event(ev1A), .phaseNoloadIn(nl), .phaseEventIn(pe),
    .phaseSignIn(sg), .currentPeakIn(ip), .voltagePeakIn(vp),
    .swResetBusy_q(), .link(ifA));
  dims_device u_dims_device_b (.clk(clk), .sys_rst(sys_rst), .irq0Event(ev0B),
    .irq1Event(ev1B), .phaseNoloadIn(nl), .phaseEventIn(pe),
    .phaseSignIn(sg), .currentPeakIn(ip), .voltagePeakIn(vp),
    .swResetBusy_q(swBusyB), .link(ifB));
  dims_host u_dims_host (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqOut(irqOut),
    .link(ifA));
  dims_sva u_dims_sva (.clk(clk), .sys_rst(sys_rst), .regReq(ifA.regReq),
    .regWr(ifA.regWr), .regAddr(ifA.regAddr), .regWdata(ifA.regWdata),
    .regRdata(ifA.regRdata), .regAck(ifA.regAck),
    .firstIntOutN(ifA.firstIntOutN), .secondIntOutN(ifA.secondIntOutN));
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    summarize();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        hang();
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Bench acts as host on the second link; p1 pulses bank 1 with the request
  task automatic lnk(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic [31:0] p1, output logic [31:0] rd);
    int n;
    n = 0;
    ifB.regReq <= 1'b1;
    ifB.regWr <= w;
    ifB.regAddr <= a;
    ifB.regWdata <= d;
    ev1B <= p1;
    do
    begin
      @(posedge clk);
      ev1B <= 32'h0;
      n++;
      if (n > 50)
        hang();
    end
    while (ifB.regAck !== 1'b1);
    rd = ifB.regRdata;
    ifB.regReq <= 1'b0;
    @(posedge clk);
  endtask
  task automatic lw(input logic [15:0] a, input logic [31:0] d);
    lnk(1'b1, a, d, 32'h0, tmp);
  endtask
  task automatic lchk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    lnk(1'b0, a, 32'h0, 32'h0, v);
    check(v, exp);
  endtask
  task automatic pulse(input logic b0, input logic [31:0] bits);
    if (b0)
      ev0B <= bits;
    else
      ev1B <= bits;
    @(posedge clk);
    ev0B <= 32'h0;
    ev1B <= 32'h0;
    @(posedge clk);
    @(posedge clk);
  endtask
  task automatic t_unmask();
    check(ifB.firstIntOutN, 1'b1);
    check(ifB.secondIntOutN, 1'b0);
    lchk(dims_pkg::DEV_FIRST_INT_OUT_N_ENABLE_MASK, 32'h0);
    lchk(dims_pkg::DEV_SECOND_INT_OUT_N_ENABLE_MASK, 32'h0);
    lchk(dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, dims_pkg::RESET_DONE_MASK);
    lchk(16'h00FC, 32'h0);
    lw(dims_pkg::DEV_SECOND_INT_OUT_N_ENABLE_MASK, dims_pkg::RESET_DONE_MASK);
    lchk(dims_pkg::DEV_SECOND_INT_OUT_N_ENABLE_MASK, dims_pkg::RESET_DONE_MASK);
    lw(dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, 32'h0);
    check(ifB.secondIntOutN, 1'b0);
    lw(dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, dims_pkg::RESET_DONE_MASK);
    check(ifB.secondIntOutN, 1'b1);
    lw(dims_pkg::DEV_SECOND_INT_OUT_N_ENABLE_MASK, 32'h0);
  endtask
  task automatic t_bank0();
    pulse(1'b1, 32'h28);
    lchk(dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS, 32'h28);
    check(ifB.firstIntOutN, 1'b1);
    lw(dims_pkg::DEV_FIRST_INT_OUT_N_ENABLE_MASK, 32'h28);
    check(ifB.firstIntOutN, 1'b0);
    lw(dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS, 32'h0);
    lchk(dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS, 32'h28);
    lw(dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS, 32'h8);
    check(ifB.firstIntOutN, 1'b0);
    lw(dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS, 32'h20);
    check(ifB.firstIntOutN, 1'b1);
    lw(dims_pkg::DEV_FIRST_INT_OUT_N_ENABLE_MASK, 32'h0);
  endtask
  task automatic t_detail();
    logic [31:0] bits [5];
    logic [15:0] adr [5];
    logic [31:0] val [5];
    logic [15:0] sa;
    bits = '{32'h1, 32'h2_0000, 32'h80_0000, 32'h100_0000, 32'h200};
    adr = '{dims_pkg::DEV_PH_NOLOAD, dims_pkg::DEV_PH_EVENT,
      dims_pkg::DEV_I_PEAK, dims_pkg::DEV_V_PEAK, dims_pkg::DEV_PH_SIGN};
    val = '{32'h1111, 32'h2222, 32'h4444_4444, 32'h5555_5555, 32'h3333};
    for (int i = 0; i < 5; i++)
    begin
      sa = (i == 4) ? dims_pkg::DEV_FIRST_INT_OUT_N_EVENT_FLAGS : dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS;
      pulse(i == 4, bits[i]);
      lchk(sa, bits[i]);
      lchk(adr[i], val[i]);
      lw(sa, bits[i]);
    end
  endtask
  // Clear and event meet at the same take edge: the event has to survive
  task automatic t_setwins();
    pulse(1'b0, 32'h1_0000);
    lnk(1'b1, dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, 32'h1_0000, 32'h1_0000, tmp);
    lchk(dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, 32'h1_0000);
    lw(dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, 32'h1_0000);
    lchk(dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, 32'h0);
  endtask
  // Software reset must clear masks and raise reset-done again
  task automatic t_swreset();
    lw(dims_pkg::DEV_FIRST_INT_OUT_N_ENABLE_MASK, 32'h28);
    lw(dims_pkg::DEV_SW_RESET, 32'h0);
    check(swBusyB, 1'b1);
    lchk(dims_pkg::DEV_FIRST_INT_OUT_N_ENABLE_MASK, 32'h0);
    lchk(dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, dims_pkg::RESET_DONE_MASK);
    check(ifB.secondIntOutN, 1'b0);
    check(swBusyB, 1'b0);
    lw(dims_pkg::DEV_SECOND_INT_OUT_N_EVENT_FLAGS, dims_pkg::RESET_DONE_MASK);
  endtask
  task automatic t_host();
    logic [31:0] v;
    logic e;
    int n;
    check(ifA.secondIntOutN, 1'b0);
    // A no-load flag beside reset-done forces a detail read in service
    ev1A <= 32'h1;
    @(posedge clk);
    ev1A <= 32'h0;
    apb(1'b1, dims_pkg::HOST_CTRL, 32'h1, v, e);
    n = 0;
    while (ifA.secondIntOutN !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 200)
        hang();
    end
    check(irqOut, 1'b0);
    apb(1'b0, dims_pkg::HOST_IRQ_STAT, 32'h0, v, e);
    check(v, 32'h6);
    apb(1'b0, dims_pkg::HOST_LAST_ST1, 32'h0, v, e);
    check(v, dims_pkg::RESET_DONE_MASK | 32'h1);
    apb(1'b0, dims_pkg::HOST_LAST_DET, 32'h0, v, e);
    check(v, 32'h1111);
    apb(1'b1, dims_pkg::HOST_IRQ_MASK, 32'h2, v, e);
    @(posedge clk);
    check(irqOut, 1'b1);
    apb(1'b1, dims_pkg::HOST_IRQ_STAT, 32'h2, v, e);
    @(posedge clk);
    check(irqOut, 1'b0);
    apb(1'b0, 8'hFC, 32'h0, v, e);
    check(e, 1'b1);
    check(v, 32'h0);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    bad_count = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ev0B = 32'h0;
    ev1B = 32'h0;
    ev1A = 32'h0;
    nl = 16'h1111;
    pe = 16'h2222;
    sg = 16'h3333;
    ip = 32'h4444_4444;
    vp = 32'h5555_5555;
    ifB.regReq = 1'b0;
    ifB.regWr = 1'b0;
    ifB.regAddr = 16'h0;
    ifB.regWdata = 32'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_unmask();
    t_bank0();
    t_detail();
    t_setwins();
    t_swreset();
    t_host();
    summarize();
  end
endmodule
`default_nettype wire
